/* File: hw/shs_homing_sequencer.sv */
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module shs_homing_sequencer
   import shs_pkg::*;
(
   // Bus clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Feedback and switches
   input wire logic [31:0] actual_position,
   input wire logic [31:0] following_error,
   input wire logic reference_switch,
   input wire logic limit_switch,
   input wire logic feedback_zero_mark,
   input wire logic mechanical_stop,
   input wire logic [31:0] ssi_position,
   // Drive control
   output logic software_drive_enable,
   output logic move_request,
   output logic move_direction,
   output logic [15:0] peak_current_limit,
   output logic position_set,
   output logic discard_following_error,
   output logic target_set,
   output logic [31:0] set_value,
   output logic [31:0] reported_position,
   output logic [1:0] crossings_per_turn,
   output logic in_position_flag,
   output logic position_controller_enable
);

   shs_state_type s;
   shs_state_type next_s;
   logic start_edge;
   logic uses_zero_pulse;
   logic [31:0] home_value;
   logic [47:0] ssi_scaled;

   // ****************************************
   // Derived terms
   // ****************************************
   // Held start level: only its rising edge starts a run
   assign start_edge = s.start_cmd && !s.start_prev;
   assign uses_zero_pulse = (s.homing_type_select >= SHS_TYPE_REF_MARK &&
      s.homing_type_select <= SHS_TYPE_NEXT_MARK) ||
      s.homing_type_select == SHS_TYPE_STOP_MARK;
   // Zero point lands on the emulated zero pulse offset
   assign home_value = s.reference_offset + (uses_zero_pulse ? s.zero_pulse_offset : 32'h0);
   // Zero output factor would divide by zero, so the division is skipped then
   assign ssi_scaled = (s.gear_output_factor == 16'h0) ?
      48'(ssi_position) * 48'(s.gear_input_factor) :
      (48'(ssi_position) * 48'(s.gear_input_factor)) / 48'(s.gear_output_factor);

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      logic [31:0] rdata;
      logic switch_hit;
      rdata = 32'h0;
      switch_hit = 1'b0;
      next_s = s;
      next_s.hreadyout = 1'b1;
      next_s.stop_pulse = 1'b0;
      next_s.position_set = 1'b0;
      next_s.target_set = 1'b0;
      next_s.start_prev = s.start_cmd;
      next_s.ref_prev = reference_switch;
      next_s.lim_prev = limit_switch;

      // Read mux, decoded in the address phase so hrdata is a flop
      if (haddr[7:0] == SHS_CTRL_OFFSET)
      begin
         rdata[SHS_CTRL_START_BIT] = s.start_cmd;
      end
      else if (haddr[7:0] == SHS_MODE_OFFSET)
      begin
         rdata[SHS_MODE_OPERATING_MODE_SELECT_LSB +: 4] = s.operating_mode_select;
         rdata[SHS_MODE_TYPE_LSB +: 5] = s.homing_type_select;
         rdata[SHS_MODE_DIR_BIT] = s.homing_direction;
         rdata[SHS_MODE_GEARSRC_LSB +: 3] = s.gearing_source_select;
         rdata[SHS_MODE_POLES_LSB +: 2] = s.feedback_poles;
      end
      else if (haddr[7:0] == SHS_REF_OFFSET_OFFSET)
         rdata = s.reference_offset;
      else if (haddr[7:0] == SHS_WINDOW_OFFSET)
         rdata = s.contouring_error_window;
      else if (haddr[7:0] == SHS_ZERO_PULSE_OFFSET)
         rdata = s.zero_pulse_offset;
      else if (haddr[7:0] == SHS_CURRENT_OFFSET)
         rdata = {s.homing_peak_current, s.peak_current_setting};
      else if (haddr[7:0] == SHS_GEAR_OFFSET)
         rdata = {s.gear_output_factor, s.gear_input_factor};
      else if (haddr[7:0] == SHS_STATUS_OFFSET)
         rdata = {21'h0, s.crossings_per_turn, s.homed, s.position_controller_enable,
            s.in_position_flag, s.move_request, s.software_drive_enable, 1'b0, s.phase};
      else if (haddr[7:0] == SHS_REPORTED_OFFSET)
         rdata = s.reported_position;
      else if (haddr[7:0] == SHS_SET_VALUE_OFFSET)
         rdata = s.set_value;

      // Address phase capture; unmapped offsets read zero, writes dropped
      next_s.bus_valid = hsel && htrans[1] && hready;
      if (hsel && htrans[1] && hready)
      begin
         next_s.bus_addr = haddr[7:0];
         next_s.bus_write = hwrite;
         if (!hwrite)
            next_s.hrdata = rdata;
      end

      // Data phase write
      if (s.bus_valid && s.bus_write)
      begin
         if (s.bus_addr == SHS_CTRL_OFFSET)
         begin
            next_s.start_cmd = hwdata[SHS_CTRL_START_BIT];
            next_s.stop_pulse = hwdata[SHS_CTRL_STOP_BIT];
         end
         else if (s.bus_addr == SHS_MODE_OFFSET)
         begin
            next_s.operating_mode_select = hwdata[SHS_MODE_OPERATING_MODE_SELECT_LSB +: 4];
            if (hwdata[SHS_MODE_TYPE_LSB +: 5] <= SHS_TYPE_MAX)
               next_s.homing_type_select = hwdata[SHS_MODE_TYPE_LSB +: 5];
            next_s.homing_direction = hwdata[SHS_MODE_DIR_BIT];
            next_s.gearing_source_select = hwdata[SHS_MODE_GEARSRC_LSB +: 3];
            next_s.feedback_poles = hwdata[SHS_MODE_POLES_LSB +: 2];
         end
         else if (s.bus_addr == SHS_REF_OFFSET_OFFSET)
            next_s.reference_offset = hwdata;
         else if (s.bus_addr == SHS_WINDOW_OFFSET)
            next_s.contouring_error_window = hwdata;
         else if (s.bus_addr == SHS_ZERO_PULSE_OFFSET)
            next_s.zero_pulse_offset = hwdata;
         else if (s.bus_addr == SHS_CURRENT_OFFSET)
         begin
            next_s.peak_current_setting = hwdata[15:0];
            next_s.homing_peak_current = hwdata[31:16];
         end
         else if (s.bus_addr == SHS_GEAR_OFFSET)
         begin
            next_s.gear_input_factor = hwdata[15:0];
            next_s.gear_output_factor = hwdata[31:16];
         end
      end

      // Position shown to software; type five shows the true position
      next_s.reported_position = actual_position +
         ((s.homing_type_select == SHS_TYPE_NEXT_MARK) ? 32'h0 : s.zero_pulse_offset);

      // Zero crossings per motor turn from the feedback pole count
      if (s.feedback_poles == SHS_POLES_FOUR)
         next_s.crossings_per_turn = SHS_CROSS_TWO;
      else if (s.feedback_poles == SHS_POLES_SIX)
         next_s.crossings_per_turn = SHS_CROSS_THREE;
      else
         next_s.crossings_per_turn = SHS_CROSS_ONE;

      // Peak limit follows the setting except during a stall search
      if (s.phase != SHS_SEEK_STALL)
         next_s.peak_current_limit = s.peak_current_setting;

      // Which switch ends the search: home switch for 1 and 3, limit otherwise
      if (s.homing_type_select == SHS_TYPE_REF_MARK ||
         s.homing_type_select == SHS_TYPE_REF_EDGE)
         switch_hit = reference_switch != s.ref_prev;
      else
         switch_hit = limit_switch && !s.lim_prev;

      // Sequencer; a stop outranks a start seen in the same cycle
      if (s.stop_pulse)
      begin
         next_s.phase = SHS_IDLE;
         next_s.move_request = 1'b0;
         next_s.peak_current_limit = s.peak_current_setting;
      end
      else if (start_edge)
      begin
         next_s.software_drive_enable = 1'b1;
         next_s.in_position_flag = 1'b0;
         next_s.position_controller_enable = 1'b0;
         next_s.move_direction = s.homing_direction;
         next_s.set_value = s.reference_offset;
         if (s.operating_mode_select == SHS_POSITIONING_MODE)
         begin
            case (s.homing_type_select)
               SHS_TYPE_SET_OFFSET:
               begin
                  next_s.position_set = 1'b1;
                  next_s.discard_following_error = 1'b1;
                  next_s.phase = SHS_DONE;
               end
               SHS_TYPE_SET_ACTUAL:
               begin
                  next_s.position_set = 1'b1;
                  next_s.discard_following_error = 1'b0;
                  next_s.phase = SHS_DONE;
               end
               SHS_TYPE_REF_MARK, SHS_TYPE_LIM_MARK, SHS_TYPE_REF_EDGE, SHS_TYPE_LIM_EDGE:
               begin
                  next_s.move_request = 1'b1;
                  next_s.phase = SHS_SEEK_SWITCH;
               end
               SHS_TYPE_NEXT_MARK:
               begin
                  next_s.move_request = 1'b1;
                  next_s.phase = SHS_SEEK_MARK;
               end
               SHS_TYPE_STOP_MARK:
               begin
                  next_s.move_request = 1'b1;
                  next_s.phase = SHS_SEEK_STOP;
               end
               SHS_TYPE_SSI:
               begin
                  // Without the SSI source there is nothing to capture
                  if (s.gearing_source_select == SHS_GEARSRC_SSI)
                  begin
                     next_s.target_set = 1'b1;
                     next_s.set_value = ssi_scaled[31:0] + s.reference_offset;
                  end
                  next_s.phase = SHS_DONE;
               end
               SHS_TYPE_STALL:
               begin
                  next_s.move_request = 1'b1;
                  next_s.peak_current_limit = s.homing_peak_current;
                  next_s.phase = SHS_SEEK_STALL;
               end
               default:
                  next_s.phase = SHS_DONE;
            endcase
         end
      end
      else
      begin
         case (s.phase)
            SHS_SEEK_SWITCH:
               if (switch_hit)
               begin
                  if (s.homing_type_select == SHS_TYPE_REF_MARK ||
                     s.homing_type_select == SHS_TYPE_LIM_MARK)
                     next_s.phase = SHS_SEEK_MARK;
                  else
                  begin
                     next_s.position_set = 1'b1;
                     next_s.discard_following_error = 1'b1;
                     next_s.set_value = home_value;
                     next_s.move_request = 1'b0;
                     next_s.phase = SHS_DONE;
                  end
               end
            SHS_SEEK_STOP:
               if (mechanical_stop)
                  next_s.phase = SHS_SEEK_MARK;
            SHS_SEEK_MARK:
               // First zero crossing after the transition wins
               if (feedback_zero_mark)
               begin
                  next_s.position_set = 1'b1;
                  next_s.discard_following_error = 1'b1;
                  next_s.set_value = home_value;
                  next_s.move_request = 1'b0;
                  next_s.phase = SHS_DONE;
               end
            SHS_SEEK_STALL:
               if (following_error > (s.contouring_error_window >> 1))
               begin
                  next_s.position_set = 1'b1;
                  next_s.target_set = 1'b1;
                  next_s.discard_following_error = 1'b1;
                  next_s.set_value = s.reference_offset;
                  next_s.peak_current_limit = s.peak_current_setting;
                  next_s.move_request = 1'b0;
                  next_s.phase = SHS_DONE;
               end
            SHS_DONE:
            begin
               next_s.in_position_flag = 1'b1;
               next_s.phase = SHS_ENABLE;
            end
            SHS_ENABLE:
            begin
               next_s.position_controller_enable = 1'b1;
               next_s.homed = 1'b1;
               next_s.phase = SHS_IDLE;
            end
            default:
               next_s.phase = SHS_IDLE;
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   // All-zero reset: type zero, idle, drive enable off
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s <= '0;
      else
         s <= next_s;
   end

   // Outputs straight from the state flops, except hresp tied to zero
   assign hrdata = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp = 1'b0;
   assign software_drive_enable = s.software_drive_enable;
   assign move_request = s.move_request;
   assign move_direction = s.move_direction;
   assign peak_current_limit = s.peak_current_limit;
   assign position_set = s.position_set;
   assign discard_following_error = s.discard_following_error;
   assign target_set = s.target_set;
   assign set_value = s.set_value;
   assign reported_position = s.reported_position;
   assign crossings_per_turn = s.crossings_per_turn;
   assign in_position_flag = s.in_position_flag;
   assign position_controller_enable = s.position_controller_enable;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   AST_START_ENABLES: assert property (
      start_edge && !s.stop_pulse |=> software_drive_enable)
      else $error("start did not set drive enable");

   AST_NO_MOVE_OUTSIDE_MODE: assert property (
      start_edge && !s.stop_pulse && s.operating_mode_select != SHS_POSITIONING_MODE
      && !move_request |=> !move_request)
      else $error("movement began outside positioning mode");

   AST_STOP_CANCELS: assert property (
      s.stop_pulse |=> !move_request && s.phase == SHS_IDLE
      && software_drive_enable == $past(software_drive_enable))
      else $error("stop did not cancel homing or changed enable");

   AST_TYPE_IN_RANGE: assert property (
      s.homing_type_select <= SHS_TYPE_MAX)
      else $error("homing type outside accepted range");

   AST_TYPE_ZERO_LOADS: assert property (
      start_edge && !s.stop_pulse && s.operating_mode_select == SHS_POSITIONING_MODE
      && s.homing_type_select == SHS_TYPE_SET_OFFSET
      |=> position_set && discard_following_error && set_value == $past(s.reference_offset)
      ##1 in_position_flag ##1 position_controller_enable)
      else $error("type zero sequence wrong");

   AST_STALL_CURRENT: assert property (
      s.phase == SHS_SEEK_STALL |-> peak_current_limit == s.homing_peak_current)
      else $error("stall search without homing peak current");

   AST_STALL_RESTORE: assert property (
      s.phase == SHS_SEEK_STALL && !s.stop_pulse && !start_edge
      && following_error > (s.contouring_error_window >> 1)
      |=> position_set && target_set && set_value == $past(s.reference_offset)
      ##1 peak_current_limit == s.peak_current_setting)
      else $error("stall end did not set offset or restore current");

   AST_INPOS_FIRST: assert property (
      $rose(position_controller_enable) |-> $past(in_position_flag))
      else $error("controller enabled before in position");

   AST_REPORTED: assert property (
      ##1 s.homing_type_select == SHS_TYPE_NEXT_MARK
      && $past(s.homing_type_select) == SHS_TYPE_NEXT_MARK
      |-> reported_position == $past(actual_position))
      else $error("type five position not the true position");

endmodule // shs_homing_sequencer

/* File: hw/shs_pkg.sv */
package shs_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] SHS_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] SHS_MODE_OFFSET = 8'h04;
   localparam logic [7:0] SHS_REF_OFFSET_OFFSET = 8'h08;
   localparam logic [7:0] SHS_WINDOW_OFFSET = 8'h0c;
   localparam logic [7:0] SHS_ZERO_PULSE_OFFSET = 8'h10;
   localparam logic [7:0] SHS_CURRENT_OFFSET = 8'h14;
   localparam logic [7:0] SHS_GEAR_OFFSET = 8'h18;
   localparam logic [7:0] SHS_STATUS_OFFSET = 8'h1c;
   localparam logic [7:0] SHS_REPORTED_OFFSET = 8'h20;
   localparam logic [7:0] SHS_SET_VALUE_OFFSET = 8'h24;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int SHS_CTRL_START_BIT = 0;
   localparam int SHS_CTRL_STOP_BIT = 1;
   localparam int SHS_MODE_OPERATING_MODE_SELECT_LSB = 0;
   localparam int SHS_MODE_TYPE_LSB = 8;
   localparam int SHS_MODE_DIR_BIT = 16;
   localparam int SHS_MODE_GEARSRC_LSB = 20;
   localparam int SHS_MODE_POLES_LSB = 24;
   localparam int SHS_HALF_LSB = 16;

   // ****************************************
   // Encodings
   // ****************************************
   localparam logic [3:0] SHS_POSITIONING_MODE = 4'h8;
   localparam logic [4:0] SHS_TYPE_MAX = 5'h14;
   localparam logic [4:0] SHS_TYPE_SET_OFFSET = 5'h00;
   localparam logic [4:0] SHS_TYPE_REF_MARK = 5'h01;
   localparam logic [4:0] SHS_TYPE_LIM_MARK = 5'h02;
   localparam logic [4:0] SHS_TYPE_REF_EDGE = 5'h03;
   localparam logic [4:0] SHS_TYPE_LIM_EDGE = 5'h04;
   localparam logic [4:0] SHS_TYPE_NEXT_MARK = 5'h05;
   localparam logic [4:0] SHS_TYPE_SET_ACTUAL = 5'h06;
   localparam logic [4:0] SHS_TYPE_STOP_MARK = 5'h07;
   localparam logic [4:0] SHS_TYPE_SSI = 5'h08;
   localparam logic [4:0] SHS_TYPE_STALL = 5'h09;
   localparam logic [2:0] SHS_GEARSRC_SSI = 3'h5;
   localparam logic [1:0] SHS_POLES_FOUR = 2'h1;
   localparam logic [1:0] SHS_POLES_SIX = 2'h2;
   localparam logic [1:0] SHS_CROSS_ONE = 2'h1;
   localparam logic [1:0] SHS_CROSS_TWO = 2'h2;
   localparam logic [1:0] SHS_CROSS_THREE = 2'h3;

   typedef enum logic [2:0] {
      SHS_IDLE, SHS_SEEK_SWITCH, SHS_SEEK_MARK, SHS_SEEK_STOP, SHS_SEEK_STALL,
      SHS_DONE, SHS_ENABLE
   } shs_phase_type;

   // Whole module state, registered as one word
   typedef struct packed {
      logic bus_valid;
      logic bus_write;
      logic [7:0] bus_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic start_cmd;
      logic start_prev;
      logic stop_pulse;
      logic [3:0] operating_mode_select;
      logic [4:0] homing_type_select;
      logic homing_direction;
      logic [2:0] gearing_source_select;
      logic [1:0] feedback_poles;
      logic [31:0] reference_offset;
      logic [31:0] contouring_error_window;
      logic [31:0] zero_pulse_offset;
      logic [15:0] homing_peak_current;
      logic [15:0] peak_current_setting;
      logic [15:0] gear_input_factor;
      logic [15:0] gear_output_factor;
      shs_phase_type phase;
      logic ref_prev;
      logic lim_prev;
      logic software_drive_enable;
      logic move_request;
      logic move_direction;
      logic [15:0] peak_current_limit;
      logic position_set;
      logic discard_following_error;
      logic target_set;
      logic [31:0] set_value;
      logic [31:0] reported_position;
      logic [1:0] crossings_per_turn;
      logic in_position_flag;
      logic position_controller_enable;
      logic homed;
   } shs_state_type;

endpackage

/* File: test/shs_axis_model.sv */
`timescale 1ns/1ps
module shs_axis_model (
   // Clock
   input wire logic hclk,
   // Drive side
   input wire logic move_request,
   input wire logic [7:0] delay,
   // Feedback and switches
   output logic [31:0] actual_position,
   output logic [31:0] following_error,
   output logic reference_switch,
   output logic limit_switch,
   output logic feedback_zero_mark,
   output logic mechanical_stop
);
   logic [7:0] cnt = 8'h0;
   logic hit;
   assign hit = move_request && cnt >= delay;
   initial actual_position = 32'h100;
   initial reference_switch = 1'b0;
   // ****************************************
   // Axis travel
   // ****************************************
   // Early zero mark comes before any switch, so it must be ignored
   always @(posedge hclk)
   begin
      cnt <= move_request ? cnt + 8'h1 : 8'h0;
      actual_position <= actual_position + {31'h0, move_request};
      feedback_zero_mark <= move_request && (cnt == 8'h1 || cnt == delay + 8'h3);
      limit_switch <= hit;
      mechanical_stop <= hit;
      following_error <= hit ? 32'h50 : 32'h0;
      if (move_request && cnt == delay)
         reference_switch <= ~reference_switch;
   end
endmodule // shs_axis_model

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import shs_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ssi = 32'h0, rd, cap = 32'h0;
   logic [31:0] ap, fe, sv, rp, off, zp;
   logic [1:0] htrans = 2'h0, cpt;
   logic [15:0] plim, pk = 16'h0;
   logic [7:0] dly = 8'h4;
   logic hro, hresp, de, mr, mdir, ps, dfe, ts, ip, pce, rs, ls, zm, ms;
   int fail_count = 0, n_compared = 0, np = 0, mv = 0, n0, m0, nt = 0, t0;
   logic cf = 1'b0;
   logic [4:0] types [11] = '{5'h0, 5'h3, 5'h1, 5'h2, 5'h4, 5'h5, 5'h7, 5'h9, 5'h8, 5'h6, 5'h14};
   shs_homing_sequencer shs_homing_sequencer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hro), .hrdata(hrdata), .hreadyout(hro), .hresp(hresp), .actual_position(ap),
      .following_error(fe), .reference_switch(rs), .limit_switch(ls), .feedback_zero_mark(zm),
      .mechanical_stop(ms), .ssi_position(ssi), .software_drive_enable(de), .move_request(mr),
      .move_direction(mdir), .peak_current_limit(plim), .position_set(ps),
      .discard_following_error(dfe), .target_set(ts), .set_value(sv), .reported_position(rp),
      .crossings_per_turn(cpt), .in_position_flag(ip), .position_controller_enable(pce));
   shs_axis_model shs_axis_model_i (.hclk(hclk), .move_request(mr), .delay(dly),
      .actual_position(ap), .following_error(fe), .reference_switch(rs), .limit_switch(ls),
      .feedback_zero_mark(zm), .mechanical_stop(ms));
   initial forever #5 hclk = ~hclk;
   // ****************************************
   // Result capture and checking
   // ****************************************
   // Load pulses last one cycle, so they are caught on every edge
   always @(posedge hclk)
   begin
      if (ps === 1'b1 || ts === 1'b1) begin cap <= sv; np <= np + 1; end
      if (mr === 1'b1) begin mv <= mv + 1; pk <= plim; end
      if (ps === 1'b1) cf <= dfe;
      if (ts === 1'b1) nt <= nt + 1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Bounded wait for hready; a hang ends the run
   task automatic wt();
      int k;
      k = 0;
      @(posedge hclk);
      while (hro !== 1'b1)
      begin
         k++;
         if (k > 50) begin fail_count++; results(); end
         @(posedge hclk);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
      wt();
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      wt();
      #1 rd = hrdata;
   endtask
   task automatic wip(input int lim);
      int k;
      for (k = 0; k < lim && ip !== 1'b1; k++) @(posedge hclk) #1;
      if (ip !== 1'b1) begin fail_count++; results(); end
   endtask
   // One homing run of type t in operating mode om
   task automatic run(input logic [4:0] t, input logic [3:0] om);
      logic [31:0] e;
      e = (t == 5'h8) ? ssi * 32'h3 / 32'h2 + off : (t == 5'h0 || t == 5'h6 || t == 5'h9)
         ? off : off + zp;
      bus(1'b1, SHS_MODE_OFFSET,
         {6'h0, 2'(t % 3), 1'b0, SHS_GEARSRC_SSI, 3'h0, t[0], 3'h0, t, 4'h0, om});
      n0 = np; m0 = mv;
      t0 = nt;
      bus(1'b1, SHS_CTRL_OFFSET, 32'h0);
      bus(1'b1, SHS_CTRL_OFFSET, 32'h1);
      // The old in-position level stands until the start edge clears it
      @(posedge hclk) #1;
      if (om == SHS_POSITIONING_MODE)
      begin
         wip(400);
         chk(pce, 1'b0);
         @(posedge hclk) #1 chk(pce, 1'b1);
      end
      else
      begin
         repeat (4) @(posedge hclk) #1;
         chk(ip, 1'b0);
         chk(pce, 1'b0);
      end
      chk(de, 1'b1);
      chk(mdir, t[0]);
      chk(nt - t0, 32'(om == SHS_POSITIONING_MODE && t inside {8, 9}));
      if (np != n0 && t != 5'h8) chk(cf, t != 5'h6);
      chk(cpt, 2'(t % 3 + 1));
      chk(rp, ap + ((t == 5'h5) ? 32'h0 : zp));
      chk(32'(mv != m0), 32'(om == SHS_POSITIONING_MODE && t inside {[1:5], 7, 9}));
      chk(np - n0, 32'(om == SHS_POSITIONING_MODE && t < 5'ha));
      if (np != n0) chk(cap, e);
      if (mv != m0) chk(pk, (t == 5'h9) ? 16'h0777 : 16'h0123);
      chk(plim, 16'h0123);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      void'($urandom(32'h39d69171));
      off = $urandom;
      zp = $urandom;
      ssi = {16'h0, 16'($urandom)};
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      bus(1'b1, SHS_REF_OFFSET_OFFSET, off);
      bus(1'b1, SHS_ZERO_PULSE_OFFSET, zp);
      bus(1'b1, SHS_WINDOW_OFFSET, 32'h64);
      bus(1'b1, SHS_CURRENT_OFFSET, 32'h07770123);
      bus(1'b1, SHS_GEAR_OFFSET, 32'h00020003);
      bus(1'b0, 8'h80, 32'h0);
      chk(rd, 32'h0);
      chk(hresp, 1'b0);
      foreach (types[i])
         run(types[i], 4'h8);
      run(5'h3, 4'h1);
      bus(1'b1, SHS_MODE_OFFSET, {19'h0, 5'h15, 4'h0, 4'h8});
      bus(1'b0, SHS_MODE_OFFSET, 32'h0);
      chk(rd, 32'h00000308);
      dly <= 8'hc8;
      bus(1'b1, SHS_CTRL_OFFSET, 32'h0);
      bus(1'b1, SHS_CTRL_OFFSET, 32'h1);
      repeat (10) @(posedge hclk);
      bus(1'b1, SHS_CTRL_OFFSET, 32'h3);
      repeat (4) @(posedge hclk) #1;
      chk(mr, 1'b0);
      chk(de, 1'b1);
      chk(ip, 1'b0);
      results();
   end
endmodule // testbench
